// [src/scs_top.sv]
// Purpose: serial port clock generation, transfer engine and status register
// Assumes: pins synchronous to i_ref_clk; single register port master
// Notes:   transmit buffer is one byte deep, receive buffer one byte
//
// Contract
// (R1) Clock idles high when polarity is 1, low when 0.
// (R2) Phase with polarity picks launch and sample edges; four formats.
// (R3) Master rate field divides base clock by 4, 8, 32 or 64.
// (R4) Timer clock select picks system clock or timer overflow as base.
// (R5) Rate field is ignored in slave mode; slave follows incoming clock.
// (R6) Software programs all control fields before setting the enable bit.
// (R7) Master is enabled before any slave select goes low.
// (R8) Transfer end sets done flag, interrupts when unit irq enabled.
// (R9) Done flag clears by write or status read then data access.
// (R10) Data write while buffer full sets collision flag, transfer untouched.
// (R11) Collision flag clears by write or status read then data access.
// (R12) Master, select-ignore 0, select low sets mode fault; write clears.
// (R13) Buffer moved to shifter sets tx empty flag; software clears it.
// (R14) Tx empty interrupts only when buffer and unit enables are 1.
// (R15) Select-ignore 0: slave only while select low; master watches select.
// (R16) Select-ignore 1: slave always active, no mode fault, pin freed.
// (R17) Slave output disable tristates the slave data output.
// (R18) Shared select: first byte addresses, addressed slave clears disable.
// (R19) Master data write loads buffer and starts transfer when idle.
`include "scs_defines.svh"
`default_nettype none

module scs_top
   import scs_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_srst,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // timer overflow pulse
   input wire logic i_tick_ovf,
   // serial pins
   input wire logic i_sclk,
   input wire logic i_mosi,
   input wire logic i_miso,
   input wire logic i_sel_n,
   output logic o_sclk,
   output logic o_sclk_oe,
   output logic o_mosi,
   output logic o_mosi_oe,
   output logic o_miso,
   output logic o_miso_oe,
   output logic o_sel_pin_free,
   // interrupt
   output logic o_irq
);

   typedef struct packed
   {
      logic [7:0] ctrl;
      logic [7:0] status;
      logic [3:0] mask;
      logic irq_en;
      logic [7:0] txbuf;
      logic txfull;
      logic [7:0] shreg;
      logic [7:0] rxbuf;
      logic [3:0] bitcnt;
      scs_phase_t phase;
      logic sampled;
      logic st_read;
      logic [7:0] rdata;
      logic sclk;
      logic sclk_oe;
      logic mosi;
      logic mosi_oe;
      logic miso;
      logic miso_oe;
      logic pin_free;
      logic irq;
   } scs_st_t;

   scs_st_t st_q;
   scs_st_t st_d;
   logic half_tick;
   logic in_rise;
   logic in_fall;
   logic en;
   logic master_select;
   logic clock_idle_polarity;
   logic clock_sample_phase;
   logic select_ignore;
   logic slave_act;
   logic lead_edge;
   logic trail_edge;
   logic data_acc;
   logic in_bit;
   logic out_bit;
   logic [3:0] ev;

   // ---------------------------------------------------------------
   // rate divider and edge detect
   // ---------------------------------------------------------------
   scs_rate_div u_div
   (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_run(en & master_select & (st_q.phase != SCS_IDLE)),
      .i_timer_sel(st_q.ctrl[`SCS_CTL_TIMER_CLOCK_SELECT]),
      .i_rate(st_q.ctrl[`SCS_CTL_RATE_HI:`SCS_CTL_RATE_LO]),
      .i_tick_ovf(i_tick_ovf),
      .o_half_tick(half_tick)
   );

   scs_edge_det u_edge
   (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_sclk(i_sclk ^ clock_idle_polarity),
      .o_rise(in_rise),
      .o_fall(in_fall)
   );

   // ---------------------------------------------------------------
   // derived controls
   // ---------------------------------------------------------------
   always_comb
   begin
      en = st_q.ctrl[`SCS_CTL_EN];
      master_select = st_q.ctrl[`SCS_CTL_MASTER_SELECT];
      clock_idle_polarity = st_q.ctrl[`SCS_CTL_CLOCK_IDLE_POLARITY];
      clock_sample_phase = st_q.ctrl[`SCS_CTL_CLOCK_SAMPLE_PHASE];
      select_ignore = st_q.status[`SCS_ST_SELECT_IGNORE];
      slave_act = en & ~master_select & (select_ignore | ~i_sel_n); // R15 R16
      // slave edges follow the incoming clock, rate unused
      if (master_select)
      begin
         lead_edge = half_tick & (st_q.phase == SCS_LEAD);
         trail_edge = half_tick & (st_q.phase == SCS_TRAIL);
      end
      else
      begin
         lead_edge = slave_act & in_rise; // R5
         trail_edge = slave_act & in_fall; // R5
      end
      data_acc = (i_addr == `SCS_OFF_DATA) & (i_wr | i_rd);
      in_bit = master_select ? i_miso : i_mosi;
      out_bit = st_q.ctrl[`SCS_CTL_LSBF] ? st_q.shreg[0] : st_q.shreg[7];
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      ev = 4'h0;
      st_d.sampled = 1'b0;

      // transfer engine; clock_sample_phase 0 samples on leading edge, 1 on trailing
      if (!en)
      begin
         st_d.phase = SCS_IDLE;
         st_d.bitcnt = 4'h0;
      end
      else if (st_q.phase == SCS_IDLE)
      begin
         if (master_select && st_q.txfull)
         begin
            st_d.shreg = st_q.txbuf; // R19
            st_d.txfull = 1'b0;
            ev[`SCS_ST_TXE - 4] = 1'b1; // R13
            st_d.phase = SCS_LEAD;
            st_d.bitcnt = 4'h0;
         end
         else if (!master_select && slave_act)
         begin
            // slave echoes last byte unless new data was written
            if (st_q.txfull)
            begin
               st_d.shreg = st_q.txbuf;
               st_d.txfull = 1'b0;
               ev[`SCS_ST_TXE - 4] = 1'b1; // R13
            end
            st_d.phase = SCS_LEAD;
            st_d.bitcnt = 4'h0;
         end
      end
      else
      begin
         if (lead_edge)
         begin
            if (!clock_sample_phase)
            begin
               st_d.sampled = in_bit; // R2
               st_d.shreg = st_q.ctrl[`SCS_CTL_LSBF] ? {in_bit, st_q.shreg[7:1]}
                  : {st_q.shreg[6:0], in_bit};
            end
            st_d.phase = SCS_TRAIL;
         end
         if (trail_edge)
         begin
            if (clock_sample_phase)
            begin
               st_d.shreg = st_q.ctrl[`SCS_CTL_LSBF] ? {in_bit, st_q.shreg[7:1]}
                  : {st_q.shreg[6:0], in_bit}; // R2
            end
            st_d.bitcnt = st_q.bitcnt + 4'h1;
            st_d.phase = SCS_LEAD;
            if (st_q.bitcnt == 4'h7)
            begin
               st_d.rxbuf = st_d.shreg;
               ev[`SCS_ST_DONE - 4] = 1'b1; // R8
               st_d.phase = SCS_IDLE;
            end
         end
         // slave deselected mid-byte aborts the byte
         if (!master_select && !slave_act)
         begin
            st_d.phase = SCS_IDLE;
         end
      end

      // mode fault: drop to slave and stop
      if (en && master_select && !select_ignore && !i_sel_n) // R12 R15 R16
      begin
         ev[`SCS_ST_MODE_FAULT_FLAG - 4] = 1'b1;
         st_d.ctrl[`SCS_CTL_MASTER_SELECT] = 1'b0;
         st_d.phase = SCS_IDLE;
      end

      // register port
      st_d.rdata = 8'h00;
      if (i_rd)
      begin
         unique case (i_addr)
            `SCS_OFF_STATUS: st_d.rdata = {st_q.status[7:4], 1'b0, st_q.status[2:0]};
            `SCS_OFF_CTRL: st_d.rdata = st_q.ctrl;
            `SCS_OFF_DATA: st_d.rdata = st_q.rxbuf;
            `SCS_OFF_MASK: st_d.rdata = {4'h0, st_q.mask};
            `SCS_OFF_IRQEN: st_d.rdata = {7'h00, st_q.irq_en};
            default: st_d.rdata = 8'h00;
         endcase
         st_d.st_read = (i_addr == `SCS_OFF_STATUS);
      end
      if (data_acc && st_q.st_read)
      begin
         st_d.status[`SCS_ST_DONE] = 1'b0; // R9
         st_d.status[`SCS_ST_WRITE_COLLISION_FLAG] = 1'b0; // R11
         st_d.st_read = 1'b0;
      end
      if (i_wr)
      begin
         unique case (i_addr)
            `SCS_OFF_CTRL: st_d.ctrl = i_wdata; // R6
            `SCS_OFF_STATUS:
            begin
               // flags clear where a zero is written
               st_d.status[7:4] = st_q.status[7:4] & i_wdata[7:4]; // R9 R11 R12 R13
               st_d.status[2:0] = i_wdata[2:0];
            end
            `SCS_OFF_EVT: st_d.status[7:4] = st_d.status[7:4] & ~i_wdata[7:4];
            `SCS_OFF_MASK: st_d.mask = i_wdata[3:0];
            `SCS_OFF_IRQEN: st_d.irq_en = i_wdata[0];
            `SCS_OFF_DATA:
            begin
               if (st_q.txfull)
               begin
                  ev[`SCS_ST_WRITE_COLLISION_FLAG - 4] = 1'b1; // R10
               end
               else
               begin
                  st_d.txbuf = i_wdata; // R19
                  st_d.txfull = 1'b1;
               end
            end
            default: ;
         endcase
      end
      // hardware set wins over any clear
      st_d.status[7:4] = st_d.status[7:4] | ev;

      // pins
      if (master_select && en && st_q.phase != SCS_IDLE)
      begin
         if (half_tick)
         begin
            st_d.sclk = (st_q.phase == SCS_LEAD) ? ~clock_idle_polarity : clock_idle_polarity; // R1 R2
         end
      end
      else
      begin
         st_d.sclk = clock_idle_polarity; // R1
      end
      st_d.sclk_oe = en & master_select;
      // phase 0 holds the first bit ahead of the leading edge so data never moves on the sampling edge
      if (st_q.phase == SCS_IDLE || (clock_sample_phase ? lead_edge : trail_edge)
         || (!clock_sample_phase && st_q.phase == SCS_LEAD && !lead_edge)) // R2
      begin
         st_d.mosi = out_bit;
         st_d.miso = out_bit;
      end
      st_d.mosi_oe = en & master_select & (st_q.phase != SCS_IDLE);
      st_d.miso_oe = slave_act & ~st_q.status[`SCS_ST_SLAVE_OUT_DISABLE]; // R17
      st_d.pin_free = select_ignore; // R16

      // interrupt: done, collision and fault via unit enable and mask; tx empty needs its own too
      st_d.irq = st_q.irq_en & |(st_q.status[7:4] & {st_q.mask[3:1],
         st_q.mask[0] & st_q.status[`SCS_ST_TXEIE]}); // R8 R12 R14
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         st_q <= '0;
         st_q.ctrl <= `SCS_RST_CTRL;
         st_q.status <= `SCS_RST_STATUS;
         st_q.mask <= 4'hf;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign o_rdata = st_q.rdata;
   assign o_sclk = st_q.sclk;
   assign o_sclk_oe = st_q.sclk_oe;
   assign o_mosi = st_q.mosi;
   assign o_mosi_oe = st_q.mosi_oe;
   assign o_miso = st_q.miso;
   assign o_miso_oe = st_q.miso_oe;
   assign o_sel_pin_free = st_q.pin_free;
   assign o_irq = st_q.irq;

endmodule : scs_top

`default_nettype wire

// [src/scs_defines.svh]
// Purpose: register offsets, field positions, reset values and timing counts of the
//          serial clock and status block
// Assumes: byte-wide registers on a plain register port
// Notes:   offsets of control, data, mask and event registers are local choices
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define SCS_ADDR_W 8
`define SCS_OFF_STATUS 8'he8
`define SCS_OFF_CTRL 8'he9
`define SCS_OFF_DATA 8'hea
`define SCS_OFF_EVT 8'heb
`define SCS_OFF_MASK 8'hec
`define SCS_OFF_IRQEN 8'hed

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define SCS_CTL_TIMER_CLOCK_SELECT 7
`define SCS_CTL_EN 6
`define SCS_CTL_LSBF 5
`define SCS_CTL_MASTER_SELECT 4
`define SCS_CTL_CLOCK_IDLE_POLARITY 3
`define SCS_CTL_CLOCK_SAMPLE_PHASE 2
`define SCS_CTL_RATE_HI 1
`define SCS_CTL_RATE_LO 0

// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define SCS_ST_DONE 7
`define SCS_ST_WRITE_COLLISION_FLAG 6
`define SCS_ST_MODE_FAULT_FLAG 5
`define SCS_ST_TXE 4
`define SCS_ST_SELECT_IGNORE 2
`define SCS_ST_SLAVE_OUT_DISABLE 1
`define SCS_ST_TXEIE 0
`define SCS_ST_SW_MASK 8'h07

// ---------------------------------------------------------------
// reset values and divide ratios
// ---------------------------------------------------------------
`define SCS_RST_STATUS 8'h00
`define SCS_RST_CTRL 8'h00
`define SCS_DIV_00 7'h04
`define SCS_DIV_01 7'h08
`define SCS_DIV_10 7'h20
`define SCS_DIV_11 7'h40

`endif

// [src/scs_pkg.sv]
// Purpose: shared types of the serial clock and status block
// Assumes: scs_defines.svh carries the numbers
// Notes:   none
`default_nettype none

package scs_pkg;

   typedef enum logic [1:0]
   {
      SCS_IDLE = 2'b00,
      SCS_LEAD = 2'b01,
      SCS_TRAIL = 2'b10
   } scs_phase_t;

endpackage : scs_pkg

`default_nettype wire

// [src/scs_rate_div.sv]
// Purpose: serial bit-clock enable from system clock or timer overflow
// Assumes: i_tick_ovf is a one-cycle pulse
// Notes:   emits a pulse every half serial period
`include "scs_defines.svh"
`default_nettype none

module scs_rate_div
   import scs_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_srst,
   // control
   input wire logic i_run,
   input wire logic i_timer_sel,
   input wire logic [1:0] i_rate,
   input wire logic i_tick_ovf,
   // half-period enable
   output logic o_half_tick
);

   typedef struct packed
   {
      logic [6:0] cnt;
      logic half;
   } scs_div_st_t;

   scs_div_st_t st_q;
   scs_div_st_t st_d;
   logic base_en;
   logic [6:0] ratio;

   // ---------------------------------------------------------------
   // base clock and ratio
   // ---------------------------------------------------------------
   always_comb
   begin
      base_en = i_timer_sel ? i_tick_ovf : 1'b1; // R4
      unique case (i_rate) // R3
         2'b00: ratio = `SCS_DIV_00;
         2'b01: ratio = `SCS_DIV_01;
         2'b10: ratio = `SCS_DIV_10;
         2'b11: ratio = `SCS_DIV_11;
      endcase
   end

   always_comb
   begin
      st_d = st_q;
      st_d.half = 1'b0;
      if (!i_run)
      begin
         st_d.cnt = 7'h00;
      end
      else if (base_en)
      begin
         // two half ticks per serial period
         if (st_q.cnt >= {1'b0, ratio[6:1]} - 7'h01)
         begin
            st_d.cnt = 7'h00;
            st_d.half = 1'b1;
         end
         else
         begin
            st_d.cnt = st_q.cnt + 7'h01;
         end
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign o_half_tick = st_q.half;

endmodule : scs_rate_div

`default_nettype wire

// [src/scs_edge_det.sv]
// Purpose: edge detect of the incoming serial clock
// Assumes: inputs synchronous to i_ref_clk
// Notes:   one cycle of latency on all outputs
`default_nettype none

module scs_edge_det
   import scs_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_srst,
   // pins
   input wire logic i_sclk,
   // edges
   output logic o_rise,
   output logic o_fall
);

   typedef struct packed
   {
      logic prev;
      logic rise;
      logic fall;
   } scs_edge_st_t;

   scs_edge_st_t st_q;
   scs_edge_st_t st_d;

   always_comb
   begin
      st_d.prev = i_sclk;
      st_d.rise = i_sclk & ~st_q.prev;
      st_d.fall = ~i_sclk & st_q.prev;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign o_rise = st_q.rise;
   assign o_fall = st_q.fall;

endmodule : scs_edge_det

`default_nettype wire

// [bench/scs_top_assertions.sv]
// Purpose: port-level checks of scs_top
// Assumes: offsets from scs_defines.svh
// Notes:   control bits are tracked from register writes
`include "scs_defines.svh"
`default_nettype none

module scs_top_assertions
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_srst,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   // pins and interrupt
   input wire logic i_sel_n,
   input wire logic o_sclk,
   input wire logic o_sclk_oe,
   input wire logic o_mosi_oe,
   input wire logic o_miso_oe,
   input wire logic o_sel_pin_free,
   input wire logic o_irq
);
   logic en_q, master_select_q, pol_q, select_ignore_q, slave_out_disable_q, ien_q;

   // --------
   // tracked control bits
   // --------
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         {en_q, master_select_q, pol_q, select_ignore_q, slave_out_disable_q, ien_q} <= '0;
      else if (i_wr)
      begin
         if (i_addr == `SCS_OFF_CTRL)
            {en_q, master_select_q, pol_q} <= {i_wdata[6], i_wdata[4], i_wdata[3]};
         if (i_addr == `SCS_OFF_STATUS)
            {select_ignore_q, slave_out_disable_q} <= i_wdata[2:1];
         if (i_addr == `SCS_OFF_IRQEN)
            ien_q <= i_wdata[0];
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);

   a_sclk_idle_level: assert property (
      o_sclk_oe && !o_mosi_oe && !$past(o_mosi_oe) && !$past(o_mosi_oe, 2)
      && $past(pol_q, 2) == pol_q |-> o_sclk == pol_q) else $error("clock not idle");
   a_sclk_needs_master: assert property (
      o_sclk_oe |-> $past(master_select_q && en_q)) else $error("clock driven as slave");
   a_mosi_needs_master: assert property (
      o_mosi_oe |-> $past(master_select_q && en_q)) else $error("data driven as slave");
   a_disable_tristates: assert property (
      slave_out_disable_q && $past(slave_out_disable_q) |-> !o_miso_oe) else $error("slave out not off");
   a_slave_needs_sel: assert property (
      !select_ignore_q && $past(!select_ignore_q) && i_sel_n && $past(i_sel_n) && $past(i_sel_n, 2)
      |-> !o_miso_oe) else $error("slave out while unselected");
   a_pin_free_mirror: assert property (
      $past(select_ignore_q) == select_ignore_q |-> o_sel_pin_free == select_ignore_q) else $error("pin free wrong");
   a_irq_needs_enable: assert property (
      !ien_q && $past(!ien_q) |-> !o_irq) else $error("irq while disabled");
   a_fault_drops_clock: assert property (
      (en_q && master_select_q && !select_ignore_q && !i_sel_n) [*3] |-> ##[0:3] !o_sclk_oe)
      else $error("mode fault kept master");
endmodule : scs_top_assertions

bind scs_top scs_top_assertions scs_top_assertions_inst (.i_ref_clk(i_ref_clk),
   .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_sel_n(i_sel_n),
   .o_sclk(o_sclk), .o_sclk_oe(o_sclk_oe), .o_mosi_oe(o_mosi_oe), .o_miso_oe(o_miso_oe),
   .o_sel_pin_free(o_sel_pin_free), .o_irq(o_irq));

`default_nettype wire

// [bench/scs_slave_model.sv]
// Purpose: behavioural serial slave facing the master pins
// Assumes: format given by the bench, msb first
// Notes:   released line shows the inverse of its last bit
`default_nettype none

module scs_slave_model
(
   // serial pins
   input wire logic i_sclk,
   input wire logic i_mosi,
   input wire logic i_sel_n,
   // format and bytes
   input wire logic i_clock_idle_polarity,
   input wire logic i_clock_sample_phase,
   input wire logic [7:0] i_tx,
   output logic o_miso,
   output logic [7:0] o_rx
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh;

   initial
   begin
      o_miso = 1'b1;
      o_rx = 8'h00;
      sh = 8'h00;
   end
   always @(negedge i_sel_n)
   begin
      sh = i_tx;
      if (!i_clock_sample_phase)
      begin
         o_miso = sh[7];
         sh = sh << 1;
      end
   end
   // no pull on the line, so never leave the last bit standing
   always @(posedge i_sel_n)
      o_miso = ~o_miso;
   // --------
   // leading edge samples at phase 0, trailing at phase 1
   // --------
   always @(i_sclk)
   begin
      if (!i_sel_n && ((i_sclk != i_clock_idle_polarity) != i_clock_sample_phase))
         o_rx = {o_rx[6:0], i_mosi};
      else if (!i_sel_n)
      begin
         o_miso = sh[7];
         sh = sh << 1;
      end
   end
endmodule : scs_slave_model

`default_nettype wire

// [bench/tb_top.sv]
// Purpose: self-checking bench of scs_top
// Assumes: timer overflow every 3 cycles
// Notes:   loops cover all rate codes and clock formats
`include "scs_defines.svh"
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, srst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, tick = 1'b0, sclk_in = 1'b0;
   logic mosi_in = 1'b0, sel_n = 1'b1, slv_sel_n = 1'b1, clock_idle_polarity = 1'b0, clock_sample_phase = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, ptx = 8'h00, rdata, prx, rv, d;
   logic o_sclk, o_sclk_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe, o_pin_free, o_irq, miso_w;
   logic sclk_d = 1'b0;
   int fail_count = 0, compares = 0, seed = 62, per = 0, cyc = 0, tdiv = 0;
   logic [7:0] offs [5] = '{`SCS_OFF_STATUS, `SCS_OFF_CTRL, `SCS_OFF_MASK, `SCS_OFF_IRQEN, 8'hf0};
   logic [7:0] rstv [5] = '{8'h00, 8'h00, 8'h0f, 8'h00, 8'h00};
   wire logic sclk_w = o_sclk_oe ? o_sclk : clock_idle_polarity;
   wire logic mosi_w = o_mosi_oe ? o_mosi : 1'b1;

   scs_top scs_top_inst (.i_ref_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_tick_ovf(tick), .i_sclk(sclk_in),
      .i_mosi(mosi_in), .i_miso(miso_w), .i_sel_n(sel_n), .o_sclk(o_sclk),
      .o_sclk_oe(o_sclk_oe), .o_mosi(o_mosi), .o_mosi_oe(o_mosi_oe), .o_miso(o_miso),
      .o_miso_oe(o_miso_oe), .o_sel_pin_free(o_pin_free), .o_irq(o_irq));
   scs_slave_model scs_slave_model_inst (.i_sclk(sclk_w), .i_mosi(mosi_w),
      .i_sel_n(slv_sel_n), .i_clock_idle_polarity(clock_idle_polarity), .i_clock_sample_phase(clock_sample_phase), .i_tx(ptx), .o_miso(miso_w),
      .o_rx(prx));

   always #2 clk = ~clk;
   // timer overflow and serial period between rising clock edges
   always @(posedge clk)
   begin
      tdiv <= (tdiv == 2) ? 0 : tdiv + 1;
      tick <= (tdiv == 2);
      sclk_d <= o_sclk;
      cyc <= (o_sclk && !sclk_d) ? 1 : cyc + 1;
      if (o_sclk && !sclk_d)
         per <= cyc;
   end

   // --------
   // bus and checks
   // --------
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      rv = rdata;
      chk(rv & m, e);
   endtask : rchk
   task automatic wait_irq();
      int n;
      n = 0;
      while (o_irq !== 1'b1 && n < 4000)
      begin
         @(posedge clk);
         n++;
      end
      chk({7'h00, n == 4000}, 8'h00);
   endtask : wait_irq
   function automatic int fdiv(input logic [1:0] r, input logic t);
      fdiv = (r == 2'b00 ? 4 : r == 2'b01 ? 8 : r == 2'b10 ? 32 : 64) * (t ? 3 : 1);
   endfunction : fdiv
   task automatic give_verdict();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   // one master byte: fields first, then enable, then select the slave
   task automatic xfer(input logic [7:0] v, input logic [1:0] r, input logic t);
      wr(`SCS_OFF_CTRL, {t, 3'b001, clock_idle_polarity, clock_sample_phase, r});
      wr(`SCS_OFF_CTRL, {t, 3'b101, clock_idle_polarity, clock_sample_phase, r});
      slv_sel_n <= 1'b0;
      wr(`SCS_OFF_DATA, v);
      wait_irq();
      slv_sel_n <= 1'b1;
      chk(prx, v);
      chk(8'(per), 8'(fdiv(r, t)));
      rchk(`SCS_OFF_STATUS, 8'hf0, 8'h90);
      rchk(`SCS_OFF_DATA, 8'hff, ptx);
      rchk(`SCS_OFF_STATUS, 8'h80, 8'h00);
      chk({7'h00, o_irq}, 8'h00);
      wr(`SCS_OFF_STATUS, 8'h00);
   endtask : xfer

   initial
   begin
      #200000;
      fail_count++;
      give_verdict();
   end

   initial
   begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 5; i++)
         rchk(offs[i], 8'hff, rstv[i]);
      wr(`SCS_OFF_IRQEN, 8'h01);
      wr(`SCS_OFF_MASK, 8'h08);
      for (int i = 0; i < 4; i++)
      begin
         {clock_sample_phase, clock_idle_polarity} = i[1:0];
         ptx = 8'($random(seed));
         xfer(8'($random(seed)), i[1:0], i == 3);
      end
      // --------
      // collision while the buffer is full, tx empty interrupt
      // --------
      {clock_sample_phase, clock_idle_polarity} = 2'b00;
      wr(`SCS_OFF_CTRL, 8'h10);
      wr(`SCS_OFF_CTRL, 8'h50);
      wr(`SCS_OFF_MASK, 8'h01);
      slv_sel_n <= 1'b0;
      wr(`SCS_OFF_DATA, 8'h5a);
      repeat (4) @(posedge clk);
      rchk(`SCS_OFF_STATUS, 8'hff, 8'h10);
      chk({7'h00, o_irq}, 8'h00);
      d = 8'($random(seed));
      wr(`SCS_OFF_DATA, d);
      wr(`SCS_OFF_DATA, ~d);
      rchk(`SCS_OFF_STATUS, 8'h40, 8'h40);
      rchk(`SCS_OFF_DATA, 8'h00, 8'h00);
      rchk(`SCS_OFF_STATUS, 8'h40, 8'h00);
      wr(`SCS_OFF_STATUS, 8'h01);
      wait_irq();
      wr(`SCS_OFF_STATUS, 8'h00);
      wr(`SCS_OFF_MASK, 8'h08);
      wait_irq();
      slv_sel_n <= 1'b1;
      chk(prx, d);
      // --------
      // mode fault, then select ignored
      // --------
      wr(`SCS_OFF_MASK, 8'h02);
      sel_n <= 1'b0;
      repeat (4) @(posedge clk);
      chk({6'h00, o_sclk_oe, o_irq}, 8'h01);
      rchk(`SCS_OFF_STATUS, 8'h20, 8'h20);
      sel_n <= 1'b1;
      wr(`SCS_OFF_STATUS, 8'h00);
      rchk(`SCS_OFF_STATUS, 8'h20, 8'h00);
      wr(`SCS_OFF_STATUS, 8'h04);
      wr(`SCS_OFF_CTRL, 8'h50);
      sel_n <= 1'b0;
      repeat (4) @(posedge clk);
      rchk(`SCS_OFF_STATUS, 8'h20, 8'h00);
      chk({6'h00, o_sclk_oe, o_pin_free}, 8'h03);
      // --------
      // slave: select, ignore and output disable, then one byte
      // --------
      wr(`SCS_OFF_CTRL, 8'h40);
      for (int i = 0; i < 8; i++)
      begin
         wr(`SCS_OFF_STATUS, {5'h00, i[2:1], 1'b0});
         sel_n <= i[0];
         repeat (4) @(posedge clk);
         chk({7'h00, o_miso_oe}, {7'h00, !i[1] && (i[2] || !i[0])});
      end
      wr(`SCS_OFF_CTRL, 8'h43);
      wr(`SCS_OFF_STATUS, 8'h00);
      sel_n <= 1'b0;
      d = 8'($random(seed));
      for (int b = 7; b >= 0; b--)
      begin
         mosi_in <= d[b];
         repeat (4) @(posedge clk);
         sclk_in <= 1'b1;
         repeat (4) @(posedge clk);
         sclk_in <= 1'b0;
      end
      repeat (8) @(posedge clk);
      rchk(`SCS_OFF_STATUS, 8'h80, 8'h80);
      rchk(`SCS_OFF_DATA, 8'hff, d);
      sel_n <= 1'b1;
      give_verdict();
   end
endmodule : tb_top

`default_nettype wire
